// [hdl/mao_order.sv]
// Operation
// - mixed attributes ordered by full fences; write-through/guarded also by access fence 1
// - heavy fence and access fence 0 exist and enforce every ordering
// - guarded uncached: st-st, ld-ld, ld-st kept; st-ld by force bit or fences
// - uncached unguarded: ld-st kept; others need access fence 0 or heavy
// - write-through: ld-st kept; st-st by access fence 1; rest need full fence
// - write-back: ld-st kept; st-st, ld-ld by light fence; st-ld full fence
// - heavy fence: all earlier accesses performed before any later one
// - heavy fence ordering is cumulative across other agents' accesses
// - instruction fetches after heavy fence need not wait
// - context serialize: earlier load performed before any later load
// - load to cacheable stored location may be served locally, invisible outside
// - conditional store may complete, setting condition_field0, before performed
// - control dependencies never order accesses
// - resource dependencies never order accesses
// - accesses complete before being performed; program order only locally
// - atomic accesses to one location performed in program order
// - uncached accesses go to main memory; fences order them regardless of coherence
// - force bit keeps guarded uncached loads and stores in order end to end
// - light fence orders write-back coherent pairs except store then load
// - heavy fence keeps later instructions from starting until it completes
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module mao_order
  import mao_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core request, program order
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [ATTR_W-1:0] req_attr,
  input wire logic req_atomic,
  input wire logic req_fwd_hit,
  input wire logic req_cond,
  input wire logic req_resv_ok,
  output logic req_ready,
  // core completion
  output logic load_local,
  output logic cond_done,
  output logic condition_field0,
  output logic serialize_busy,
  // instruction fetch
  input wire logic fetch_valid,
  output logic fetch_issue,
  // memory subsystem
  output logic mem_valid,
  output logic mem_store,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [ATTR_W-1:0] mem_attr,
  output logic mem_atomic,
  input wire logic mem_ready,
  input wire logic ack_valid,
  input wire logic [1:0] ack_class,
  input wire logic ack_store,
  input wire logic ack_atomic
);
  logic hold_valid_ff;
  logic [2:0] hold_op_ff;
  logic [ADDR_W-1:0] hold_addr_ff;
  logic [ATTR_W-1:0] hold_attr_ff;
  logic hold_atomic_ff;
  logic hold_fwd_ff;
  logic hold_cond_ff;
  logic hold_resv_ff;
  logic hold_store_ff;
  logic mem_valid_ff;
  logic req_ready_ff;
  logic load_local_ff;
  logic cond_done_ff;
  logic cond_field0_ff;
  logic serialize_busy_ff;
  logic fetch_issue_ff;
  logic lf_block_ff;
  logic gof_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [1:0] hold_cls;
  logic hold_cacheable;
  logic [NGRP-1:0] grp_nz;
  logic [NGRP-1:0] grp_full;
  logic [NGRP-1:0] grp_inc;
  logic [NGRP-1:0] grp_dec;
  logic atom_nz;
  logic atom_full;
  logic is_access;
  logic is_store;
  logic is_fence;
  logic is_local;
  logic [2:0] hold_grp;
  logic ld_any;
  logic blocked;
  logic fence_done;
  logic handshake;
  logic release_hold;
  logic accept;
  logic nxt_mem_valid;
  logic apb_wr;
  logic apb_rd;

  // ==========================================================
  // decode of the held operation
  mao_classify u_classify (
    .attr(hold_attr_ff),
    .cls(hold_cls),
    .cacheable(hold_cacheable)
  );

  assign is_access = (hold_op_ff == OP_LOAD) || (hold_op_ff == OP_STORE);
  assign is_store = (hold_op_ff == OP_STORE);
  assign is_fence = hold_valid_ff && !is_access;
  assign hold_grp = grp_index(hold_cls, is_store);
  // store-queue forwarding: no outside visibility, no ordering against others
  assign is_local = hold_valid_ff && !is_store && is_access && hold_fwd_ff
                    && hold_cacheable;
  assign ld_any = |(grp_nz & MASK_LOADS);
  assign handshake = mem_valid_ff && mem_ready;

  // ==========================================================
  // outstanding access tracking, one counter per group
  genvar gi;
  generate
    for (gi = 0; gi < NGRP; gi++)
    begin : g_cnt
      assign grp_inc[gi] = handshake && (hold_grp == 3'(gi));
      // an ack means performed with respect to all agents, incl. cumulative ones
      assign grp_dec[gi] = ack_valid && (grp_index(ack_class, ack_store) == 3'(gi));
      mao_pend_count u_cnt (
        .clk(clk),
        .reset_n(reset_n),
        .inc(grp_inc[gi]),
        .dec(grp_dec[gi]),
        .nonzero(grp_nz[gi]),
        .full(grp_full[gi])
      );
    end
  endgenerate

  mao_pend_count u_atom_cnt (
    .clk(clk),
    .reset_n(reset_n),
    .inc(handshake && hold_atomic_ff),
    .dec(ack_valid && ack_atomic),
    .nonzero(atom_nz),
    .full(atom_full)
  );

  // ==========================================================
  // implicit ordering; branches and register reuse never enter here
  always_comb
  begin
    blocked = grp_full[hold_grp] || (hold_atomic_ff && atom_full);
    if (is_store && ld_any)
    begin
      blocked = 1'b1;
    end
    if ((hold_cls == CLS_CIG) && grp_nz[hold_grp])
    begin
      blocked = 1'b1;
    end
    if ((hold_cls == CLS_CIG) && !is_store && gof_ff && grp_nz[grp_index(CLS_CIG, 1'b1)])
    begin
      blocked = 1'b1;
    end
    if (is_store && (hold_cls == CLS_WB) && lf_block_ff && grp_nz[GRP_WB_ST])
    begin
      blocked = 1'b1;
    end
    if (hold_atomic_ff && atom_nz)
    begin
      blocked = 1'b1;
    end
  end

  // masks ignore the coherence bit, so heavy and access fence 0 cover all uncached traffic
  assign fence_done = is_fence && ((fence_mask(hold_op_ff) & grp_nz) == MASK_NONE);
  assign release_hold = handshake || is_local || fence_done;
  assign accept = req_valid && req_ready_ff;
  assign nxt_mem_valid = hold_valid_ff && is_access && !is_local && !blocked
                         && !handshake;

  // ==========================================================
  // holding register; completion returns before the access is performed
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_valid_ff <= 1'b0;
      hold_op_ff <= OP_LOAD;
      hold_addr_ff <= '0;
      hold_attr_ff <= '0;
      hold_atomic_ff <= 1'b0;
      hold_fwd_ff <= 1'b0;
      hold_cond_ff <= 1'b0;
      hold_resv_ff <= 1'b0;
      hold_store_ff <= 1'b0;
    end
    else if (accept)
    begin
      hold_valid_ff <= 1'b1;
      hold_op_ff <= req_op;
      hold_addr_ff <= req_addr;
      hold_attr_ff <= req_attr;
      hold_atomic_ff <= req_atomic;
      hold_fwd_ff <= req_fwd_hit;
      hold_cond_ff <= req_cond;
      hold_resv_ff <= req_resv_ok;
      hold_store_ff <= (req_op == OP_STORE);
    end
    else if (release_hold)
    begin
      hold_valid_ff <= 1'b0;
    end
  end

  // one request in flight keeps the ready flop simple; costs a bubble per access
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_ready_ff <= 1'b0;
    end
    else
    begin
      req_ready_ff <= !accept && (!hold_valid_ff || release_hold);
    end
  end

  // once raised, mem_valid stays until taken; counters only fall meanwhile
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_valid_ff <= 1'b0;
    end
    else
    begin
      mem_valid_ff <= mem_valid_ff ? !handshake : nxt_mem_valid;
    end
  end

  // ==========================================================
  // completion pulses
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      load_local_ff <= 1'b0;
      cond_done_ff <= 1'b0;
      cond_field0_ff <= 1'b0;
    end
    else
    begin
      load_local_ff <= is_local;
      cond_done_ff <= handshake && hold_cond_ff;
      if (handshake && hold_cond_ff)
      begin
        cond_field0_ff <= hold_resv_ff;
      end
    end
  end

  // ==========================================================
  // heavy fence serialisation, fetch pass, light fence store blocking
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serialize_busy_ff <= 1'b0;
      fetch_issue_ff <= 1'b0;
      lf_block_ff <= 1'b0;
    end
    else
    begin
      serialize_busy_ff <= is_fence && (hold_op_ff == OP_HEAVY) && !fence_done;
      fetch_issue_ff <= fetch_valid;
      // later loads may pass earlier stores; only later stores wait
      lf_block_ff <= ((fence_done && (hold_op_ff == OP_LIGHT)) || lf_block_ff)
                     && grp_nz[GRP_WB_ST];
    end
  end

  // ==========================================================
  // apb registers, one wait-free access phase
  assign apb_wr = psel && penable && pready_ff && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && (paddr != REG_CTRL) && (paddr != REG_STAT);
      prdata_ff <= '0;
      if (apb_rd && (paddr == REG_CTRL))
      begin
        prdata_ff[CTRL_GOF_BIT] <= gof_ff;
      end
      else if (apb_rd && (paddr == REG_STAT))
      begin
        prdata_ff[STAT_FENCE_BIT] <= is_fence;
        prdata_ff[STAT_HOLD_BIT] <= hold_valid_ff;
        prdata_ff[STAT_LBLK_BIT] <= lf_block_ff;
        prdata_ff[STAT_SER_BIT] <= serialize_busy_ff;
        prdata_ff[STAT_NZ_LSB +: NGRP] <= grp_nz;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gof_ff <= CTRL_GOF_RST;
    end
    else if (apb_wr && (paddr == REG_CTRL))
    begin
      gof_ff <= pwdata[CTRL_GOF_BIT];
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign req_ready = req_ready_ff;
  assign load_local = load_local_ff;
  assign cond_done = cond_done_ff;
  assign condition_field0 = cond_field0_ff;
  assign serialize_busy = serialize_busy_ff;
  assign fetch_issue = fetch_issue_ff;
  assign mem_valid = mem_valid_ff;
  assign mem_store = hold_store_ff;
  assign mem_addr = hold_addr_ff;
  assign mem_attr = hold_attr_ff;
  assign mem_atomic = hold_atomic_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_store_after_load: assert property ($rose(mem_valid_ff) && is_store |-> !$past(ld_any))
    else $error("store issued while a load outstanding");
  a_cig_same_type: assert property ($rose(mem_valid_ff) && (hold_cls == CLS_CIG)
    |-> !$past(grp_nz[hold_grp]))
    else $error("guarded uncached access overtook same type");
  a_force_st_ld: assert property ($rose(mem_valid_ff) && (hold_cls == CLS_CIG) && !is_store
    && $past(gof_ff) |-> !$past(grp_nz[grp_index(CLS_CIG, 1'b1)]))
    else $error("guarded load passed store with force bit set");
  a_light_store: assert property ($rose(mem_valid_ff) && is_store && (hold_cls == CLS_WB)
    && $past(lf_block_ff) |-> !$past(grp_nz[GRP_WB_ST]))
    else $error("store passed light fence");
  a_fence_pend: assert property (is_fence && ((fence_mask(hold_op_ff) & grp_nz) != MASK_NONE)
    |=> hold_valid_ff && !req_ready_ff)
    else $error("fence retired with covered accesses pending");
  a_heavy_busy: assert property (is_fence && (hold_op_ff == OP_HEAVY) && (grp_nz != MASK_NONE)
    |=> serialize_busy_ff)
    else $error("heavy fence not holding instructions");
  a_cond_early: assert property (handshake && hold_cond_ff
    |=> cond_done_ff && (cond_field0_ff == $past(hold_resv_ff)))
    else $error("conditional store completion wrong");
  a_local_load: assert property (is_local |=> load_local_ff && !mem_valid_ff)
    else $error("forwarded load reached memory");
  a_atomic_order: assert property ($rose(mem_valid_ff) && hold_atomic_ff
    |-> !$past(atom_nz))
    else $error("atomic overtook atomic");
  a_fetch_pass: assert property (fetch_valid |=> fetch_issue_ff)
    else $error("fetch held back");

  c_heavy_retire: cover property (is_fence && (hold_op_ff == OP_HEAVY) ##1 !hold_valid_ff);
  c_light_block: cover property ($rose(lf_block_ff));
  c_local_load: cover property (load_local_ff);
  c_cond_done: cover property (cond_done_ff && condition_field0);
endmodule

// [hdl/mao_pkg.sv]
package mao_pkg;
  // ==========================================================
  // storage attribute field (w i m g e)
  localparam int ATTR_W = 5;
  localparam int ATTR_W_BIT = 4;
  localparam int ATTR_I_BIT = 3;
  localparam int ATTR_M_BIT = 2;
  localparam int ATTR_G_BIT = 1;
  localparam int ADDR_W = 32;
  // ==========================================================
  // access classes
  localparam logic [1:0] CLS_CIG = 2'h0;
  localparam logic [1:0] CLS_CIN = 2'h1;
  localparam logic [1:0] CLS_WT = 2'h2;
  localparam logic [1:0] CLS_WB = 2'h3;
  // ==========================================================
  // core operation codes
  localparam logic [2:0] OP_LOAD = 3'h0;
  localparam logic [2:0] OP_STORE = 3'h1;
  localparam logic [2:0] OP_HEAVY = 3'h2;
  localparam logic [2:0] OP_ACC0 = 3'h3;
  localparam logic [2:0] OP_ACC1 = 3'h4;
  localparam logic [2:0] OP_LIGHT = 3'h5;
  localparam logic [2:0] OP_CTXSER = 3'h6;
  // ==========================================================
  // outstanding groups, index {class, store}
  localparam int NGRP = 8;
  localparam int CNT_W = 4;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_ACC1 = 8'ha3;
  localparam logic [7:0] MASK_LIGHT = 8'h40;
  localparam logic [7:0] MASK_LOADS = 8'h55;
  localparam logic [2:0] GRP_WB_ST = 3'h7;
  // ==========================================================
  // apb registers
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam int CTRL_GOF_BIT = 0;
  localparam int STAT_FENCE_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_LBLK_BIT = 2;
  localparam int STAT_SER_BIT = 3;
  localparam int STAT_NZ_LSB = 8;
  localparam logic CTRL_GOF_RST = 1'b0;

  function automatic logic [2:0] grp_index(input logic [1:0] cls, input logic store);
    grp_index = {cls, store};
  endfunction

  function automatic logic [7:0] fence_mask(input logic [2:0] op);
    case (op)
      OP_HEAVY: fence_mask = MASK_ALL;
      OP_ACC0: fence_mask = MASK_ALL;
      OP_ACC1: fence_mask = MASK_ACC1;
      OP_LIGHT: fence_mask = MASK_LIGHT;
      OP_CTXSER: fence_mask = MASK_LOADS;
      default: fence_mask = MASK_NONE;
    endcase
  endfunction
endpackage

// [hdl/mao_classify.sv]
`timescale 1ns/1ps
module mao_classify
  import mao_pkg::*;
(
  // attribute in
  input wire logic [ATTR_W-1:0] attr,
  // class out
  output logic [1:0] cls,
  output logic cacheable
);
  // ==========================================================
  // decode
  always_comb
  begin
    cacheable = ~attr[ATTR_I_BIT];
    if (attr[ATTR_I_BIT])
    begin
      cls = attr[ATTR_G_BIT] ? CLS_CIG : CLS_CIN;
    end
    else if (attr[ATTR_W_BIT])
    begin
      cls = CLS_WT;
    end
    else
    begin
      cls = CLS_WB;
    end
  end
endmodule

// [hdl/mao_pend_count.sv]
`timescale 1ns/1ps
module mao_pend_count
  import mao_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // events
  input wire logic inc,
  input wire logic dec,
  // state
  output logic nonzero,
  output logic full
);
  logic [CNT_W-1:0] cnt_ff;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // ==========================================================
  // count of issued, not yet performed accesses
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff <= '0;
    end
    else if (inc && !dec)
    begin
      cnt_ff <= cnt_ff + CNT_ONE;
    end
    else if (dec && !inc && nonzero)
    begin
      cnt_ff <= cnt_ff - CNT_ONE;
    end
  end

  assign nonzero = (cnt_ff != '0);
  assign full = (cnt_ff == CNT_MAX);
endmodule

// [verification/mao_mem_model.sv]
`timescale 1ns/1ps
// ==========================================================
// memory subsystem stand-in: takes accesses, reports them performed
module mao_mem_model
  import mao_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // test controls
  input wire logic hold,
  input wire logic slow,
  // access side
  input wire logic mem_valid,
  input wire logic mem_store,
  input wire logic [ATTR_W-1:0] mem_attr,
  input wire logic mem_atomic,
  output logic mem_ready,
  // performed reports
  output logic ack_valid,
  output logic [1:0] ack_class,
  output logic ack_store,
  output logic ack_atomic
);
  logic [3:0] q[$];
  logic [3:0] e;

  function automatic logic [1:0] cls_of(input logic [ATTR_W-1:0] a);
    if (a[ATTR_I_BIT])
      cls_of = a[ATTR_G_BIT] ? 2'h0 : 2'h1;
    else
      cls_of = a[ATTR_W_BIT] ? 2'h2 : 2'h3;
  endfunction

  // slow mode drops ready every other cycle to stretch the handshake
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      mem_ready <= 1'b0;
    else
      mem_ready <= slow ? ~mem_ready : 1'b1;

  // reports leave in issue order; hold keeps accesses unperformed
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      q.delete();
      ack_valid <= 1'b0;
      {ack_class, ack_store, ack_atomic} <= 4'h0;
    end
    else
    begin
      ack_valid <= 1'b0;
      // idle lines toggle so a stale report never looks current
      {ack_class, ack_store, ack_atomic} <= ~{ack_class, ack_store, ack_atomic};
      if (!hold && q.size() > 0)
      begin
        e = q.pop_front();
        ack_valid <= 1'b1;
        {ack_class, ack_store, ack_atomic} <= e;
      end
      if (mem_valid && mem_ready)
        q.push_back({cls_of(mem_attr), mem_store, mem_atomic});
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb
  import mao_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic req_valid = 1'b0, req_atomic = 1'b0, req_fwd_hit = 1'b0;
  logic req_cond = 1'b0, req_resv_ok = 1'b0, fetch_valid = 1'b0, mhold = 1'b0, slow = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [ADDR_W-1:0] req_addr = 32'h0, mem_addr;
  logic [ATTR_W-1:0] req_attr = 5'h00, mem_attr;
  logic req_ready, load_local, cond_done, condition_field0, serialize_busy, fetch_issue;
  logic mem_valid, mem_store, mem_atomic, mem_ready, ack_valid, ack_store, ack_atomic;
  logic [1:0] ack_class;
  logic cf_seen;
  int checks = 0, miscompares = 0, n_iss = 0, n_local = 0, n_cond = 0;
  // class order: guarded uncached, uncached, write-through, write-back
  logic [ATTR_W-1:0] attrs [4] = '{5'h0a, 5'h08, 5'h10, 5'h04};

  always #5 clk = ~clk;

  mao_order dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_attr(req_attr),
    .req_atomic(req_atomic), .req_fwd_hit(req_fwd_hit), .req_cond(req_cond),
    .req_resv_ok(req_resv_ok), .req_ready(req_ready), .load_local(load_local),
    .cond_done(cond_done), .condition_field0(condition_field0),
    .serialize_busy(serialize_busy), .fetch_valid(fetch_valid), .fetch_issue(fetch_issue),
    .mem_valid(mem_valid), .mem_store(mem_store), .mem_addr(mem_addr), .mem_attr(mem_attr),
    .mem_atomic(mem_atomic), .mem_ready(mem_ready), .ack_valid(ack_valid),
    .ack_class(ack_class), .ack_store(ack_store), .ack_atomic(ack_atomic));

  mao_mem_model mem (
    .clk(clk), .reset_n(reset_n), .hold(mhold), .slow(slow), .mem_valid(mem_valid),
    .mem_store(mem_store), .mem_attr(mem_attr), .mem_atomic(mem_atomic),
    .mem_ready(mem_ready), .ack_valid(ack_valid), .ack_class(ack_class),
    .ack_store(ack_store), .ack_atomic(ack_atomic));

  // ==========================================================
  // monitors
  always @(posedge clk)
  begin
    if (mem_valid && mem_ready)
      n_iss <= n_iss + 1;
    if (load_local)
      n_local <= n_local + 1;
    if (cond_done)
    begin
      n_cond <= n_cond + 1;
      cf_seen <= condition_field0;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic to();
    miscompares++;
    $display("wait limit reached at %0t", $time);
    results();
  endtask

  // trailing edge keeps back-to-back calls from driving psel twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (!pready && ++n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50)
      to();
  endtask

  // fl = {atomic, forward hit, conditional, reservation ok}
  task automatic req(input logic [2:0] op, input logic [ATTR_W-1:0] at, input logic [3:0] fl);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_op <= op;
    req_attr <= at;
    req_addr <= req_addr + 32'h4;
    {req_atomic, req_fwd_hit, req_cond, req_resv_ok} <= fl;
    do
      @(posedge clk);
    while (!req_ready && ++n < 100);
    req_valid <= 1'b0;
    @(posedge clk);
    if (n >= 100)
      to();
  endtask

  task automatic drain();
    logic [31:0] rd;
    logic er;
    int n;
    n = 0;
    mhold <= 1'b0;
    do
      apb(1'b0, REG_STAT, 32'h0, rd, er);
    while ((rd & 32'hff0f) !== 32'h0 && ++n < 40);
    if (n >= 40)
      to();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] rd;
    logic er;
    apb(1'b0, REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, REG_STAT, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'hffffffff, rd, er);
    apb(1'b1, 12'h008, 32'h0, rd, er);
    chk(er, 1'b1);
    apb(1'b0, REG_CTRL, 32'h0, rd, er);
    chk(rd, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0, rd, er);
    $display("test regs done");
  endtask

  task automatic t_ld_st();
    int b;
    slow <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      mhold <= 1'b1;
      b = n_iss;
      req(OP_LOAD, attrs[c], 4'h0);
      req(OP_STORE, attrs[c], 4'h0);
      repeat (8) @(posedge clk);
      chk(n_iss - b, 1);
      chk(mem_store, 1'b1);
      chk(mem_addr, req_addr);
      chk(mem_attr, attrs[c]);
      drain();
      chk(n_iss - b, 2);
    end
    slow <= 1'b0;
    $display("test load_store done");
  endtask

  task automatic t_fences();
    logic [2:0] ops [5] = '{OP_HEAVY, OP_ACC0, OP_ACC1, OP_LIGHT, OP_CTXSER};
    logic [7:0] msk [5] = '{MASK_ALL, MASK_ALL, MASK_ACC1, MASK_LIGHT, MASK_LOADS};
    int b;
    for (int f = 0; f < 5; f++)
      for (int g = 0; g < 8; g++)
      begin
        mhold <= 1'b1;
        req(g[0] ? OP_STORE : OP_LOAD, attrs[g[2:1]], 4'h0);
        req(ops[f], attrs[3], 4'h0);
        fetch_valid <= 1'b1;
        @(posedge clk);
        fetch_valid <= 1'b0;
        @(posedge clk);
        chk(fetch_issue, 1'b1);
        @(posedge clk);
        chk(req_ready, !msk[f][g]);
        chk(serialize_busy, f == 0);
        // a write-back store after a light fence must wait for the earlier one
        if (f == 3 && g == 7)
        begin
          b = n_iss;
          req(OP_STORE, attrs[3], 4'h0);
          repeat (4) @(posedge clk);
          chk(n_iss - b, 0);
        end
        drain();
      end
    $display("test fences done");
  endtask

  task automatic t_force();
    logic [31:0] rd;
    logic er;
    int b;
    for (int v = 0; v < 2; v++)
    begin
      apb(1'b1, REG_CTRL, 32'(v), rd, er);
      mhold <= 1'b1;
      b = n_iss;
      req(OP_STORE, attrs[0], 4'h0);
      req(OP_LOAD, attrs[0], 4'h0);
      repeat (8) @(posedge clk);
      chk(n_iss - b, 2 - v);
      drain();
    end
    apb(1'b1, REG_CTRL, 32'h0, rd, er);
    $display("test force done");
  endtask

  task automatic t_fwd();
    int b;
    int c;
    b = n_iss;
    c = n_local;
    req(OP_LOAD, attrs[3], 4'h4);
    repeat (4) @(posedge clk);
    chk(n_local - c, 1);
    chk(n_iss - b, 0);
    $display("test forward done");
  endtask

  task automatic t_cond();
    int c;
    mhold <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      c = n_cond;
      req(OP_STORE, attrs[3], {3'h1, v[0]});
      repeat (4) @(posedge clk);
      chk(n_cond - c, 1);
      chk(cf_seen, v[0]);
    end
    drain();
    $display("test conditional done");
  endtask

  task automatic t_atom();
    int b;
    mhold <= 1'b1;
    b = n_iss;
    req(OP_LOAD, attrs[3], 4'h8);
    req(OP_LOAD, attrs[1], 4'h8);
    repeat (8) @(posedge clk);
    chk(n_iss - b, 1);
    drain();
    chk(n_iss - b, 2);
    $display("test atomic done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_ld_st();
    t_fences();
    t_force();
    t_fwd();
    t_cond();
    t_atom();
    results();
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    to();
  end
endmodule
